// ===== rtl/ttp_pkg.sv
// Package for the tuned timer: constants, modes and carrier structs.
// Assumes a single clock domain and plain-port control from software.
package ttp_pkg;
  localparam int CNT_W = 16;
  localparam logic [2:0] MODE_ONESHOT = 3'h3;
  localparam logic [2:0] MODE_PWM     = 3'h4;
  localparam logic [2:0] MODE_FREERUN = 3'h5;
  localparam logic [3:0] CCS_ALLCMP   = 4'h0;
  localparam logic [1:0] SCCS_ALLCMP  = 2'h0;
  localparam int OPT_OVF_BIT = 0;
  localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
  localparam logic [CNT_W-1:0] CNT_ONE  = 16'h0001;
  localparam logic [CNT_W-1:0] CNT_MAX  = 16'hFFFF;
  localparam logic [1:0] EDGE_NONE = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;
  localparam logic [1:0] EDGE_BOTH = 2'h3;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_DELAY = 3'b010,
    ST_PULSE = 3'b100
  } ttp_shot_e;

  typedef struct packed {
    logic [CNT_W-1:0] masterCycle;
    logic [CNT_W-1:0] masterDuty1;
    logic [CNT_W-1:0] masterDuty2;
    logic [CNT_W-1:0] masterDuty3;
    logic [CNT_W-1:0] slaveDuty0;
    logic [CNT_W-1:0] slaveDuty1;
  } ttp_cmp_s;

  typedef struct packed {
    logic [2:0] masterMode;
    logic [3:0] masterCcs;
    logic [2:0] slaveMode;
    logic [1:0] slaveCcs;
    logic       slaveTuned;
  } ttp_cfg_s;
endpackage

// ===== rtl/ttp_timer.sv
// Tuned timer with one-shot pulse, overflow flag and timer-tuned PWM.
// Assumes software drives the control ports synchronous to clk.
//
// Function
// - One-shot: delay second compare, then active for first-second+1 counts.
// - No one-shot pulse when second compare exceeds first compare.
// - Trigger edge select picks trigger edge; separate event edge select.
// - Overflow flag cleared by bit-clear or 8-bit option write bit0 zero.
// - Bit-clear coinciding with overflow leaves flag set.
// - Plain zero write coinciding with overflow clears flag.
// - Master compare zero sets the PWM cycle.
// - Master compares one to three and slave zero, one set duties.
// - Compares rewritable while counting, applied by batch update.
// - Writing master compare one arms the batch update.
// - Armed batch loads all compares at next master cycle match.
// - Master mode field 100 selects PWM output.
// - Master compare select 0000 makes channels one to three compare; channel zero output stays low.
// - Slave tuned bit one makes slave follow master.
// - Master enable one starts tuned pair; zero ends it.
`timescale 1ns/1ps
module ttp_timer (
  input  wire logic                     clk,
  input  wire logic                     reset,
  input  wire logic                     clkEn,
  input  wire ttp_pkg::ttp_cfg_s        cfg,
  input  wire logic                     masterCountEnable,
  input  wire logic                     slaveCountEnable,
  input  wire ttp_pkg::ttp_cmp_s        cmpWrData,
  input  wire logic [5:0]               cmpWrStrobe,
  input  wire logic [15:0]              oneshotCompareFirst,
  input  wire logic [15:0]              oneshotCompareSecond,
  input  wire logic [1:0]               triggerEdgeSel,
  input  wire logic [1:0]               eventEdgeSel,
  input  wire logic                     trigPin,
  input  wire logic                     eventPin,
  input  wire logic                     overflowBitClear,
  input  wire logic                     optionWrite,
  input  wire logic [7:0]               optionWrData,
  output logic                          oneshotOut,
  output logic                          eventDetect,
  output logic                          countOverflowFlag,
  output logic [15:0]                   counterReadBuffer,
  output logic [3:0]                    masterPwmOut,
  output logic [1:0]                    slavePwmOut,
  output logic                          cycleMatchIrq
);
  ttp_pkg::ttp_cmp_s cmpStage_reg;
  ttp_pkg::ttp_cmp_s cmpActive_reg;
  logic              batchArmed_reg;
  logic [15:0]       masterCnt_reg;
  logic [15:0]       slaveCnt_reg;
  logic [15:0]       shotCnt_reg;
  ttp_pkg::ttp_shot_e shot_reg;
  logic [2:0]        trigSync_reg;
  logic [2:0]        evtSync_reg;
  logic              trigLevel_reg;
  logic              evtLevel_reg;

  // Pin synchronisers: a change counts once stages two and three agree
  always_ff @(posedge clk) begin
    if (reset) begin
      trigSync_reg  <= 3'h0;
      evtSync_reg   <= 3'h0;
      trigLevel_reg <= 1'b0;
      evtLevel_reg  <= 1'b0;
    end else if (clkEn) begin
      trigSync_reg <= {trigSync_reg[1:0], trigPin};
      evtSync_reg  <= {evtSync_reg[1:0], eventPin};
      if (trigSync_reg[1] == trigSync_reg[2])
        trigLevel_reg <= trigSync_reg[2];
      if (evtSync_reg[1] == evtSync_reg[2])
        evtLevel_reg <= evtSync_reg[2];
    end
  end

  function automatic logic edgeHit(input logic [1:0] sel, input logic prev,
                                   input logic cur);
    logic rise;
    logic fall;
    rise = !prev && cur;
    fall = prev && !cur;
    case (sel)
      ttp_pkg::EDGE_RISE: edgeHit = rise;
      ttp_pkg::EDGE_FALL: edgeHit = fall;
      ttp_pkg::EDGE_BOTH: edgeHit = rise || fall;
      default:            edgeHit = 1'b0;
    endcase
  endfunction

  wire trigStable = (trigSync_reg[1] == trigSync_reg[2]);
  wire evtStable  = (evtSync_reg[1] == evtSync_reg[2]);
  wire trigFire = trigStable &&
    edgeHit(triggerEdgeSel, trigLevel_reg, trigSync_reg[2]);
  wire evtFire = evtStable &&
    edgeHit(eventEdgeSel, evtLevel_reg, evtSync_reg[2]);

  // One-shot
  wire oneshotMode = (cfg.masterMode == ttp_pkg::MODE_ONESHOT);
  wire shotLegal = (oneshotCompareSecond <= oneshotCompareFirst);
  wire [15:0] activeLen = 16'(oneshotCompareFirst - oneshotCompareSecond);
  ttp_pkg::ttp_shot_e shot_next;
  logic [15:0] shotCnt_next;
  always_comb begin
    shot_next    = shot_reg;
    shotCnt_next = shotCnt_reg;
    case (shot_reg)
      ttp_pkg::ST_IDLE: begin
        if (masterCountEnable && oneshotMode && trigFire && shotLegal) begin
          if (oneshotCompareSecond == ttp_pkg::CNT_ZERO) begin
            shot_next    = ttp_pkg::ST_PULSE;
            shotCnt_next = activeLen;
          end else begin
            shot_next    = ttp_pkg::ST_DELAY;
            shotCnt_next = 16'(oneshotCompareSecond - ttp_pkg::CNT_ONE);
          end
        end
      end
      ttp_pkg::ST_DELAY: begin
        if (shotCnt_reg == ttp_pkg::CNT_ZERO) begin
          shot_next    = ttp_pkg::ST_PULSE;
          shotCnt_next = activeLen;
        end else begin
          shotCnt_next = 16'(shotCnt_reg - ttp_pkg::CNT_ONE);
        end
      end
      ttp_pkg::ST_PULSE: begin
        if (shotCnt_reg == ttp_pkg::CNT_ZERO) begin
          shot_next = ttp_pkg::ST_IDLE;
        end else begin
          shotCnt_next = 16'(shotCnt_reg - ttp_pkg::CNT_ONE);
        end
      end
      default: shot_next = ttp_pkg::ST_IDLE;
    endcase
    if (!masterCountEnable)
      shot_next = ttp_pkg::ST_IDLE;
  end

  // Tuned PWM counters
  wire pwmMode  = (cfg.masterMode == ttp_pkg::MODE_PWM);
  wire allCmp   = (cfg.masterCcs == ttp_pkg::CCS_ALLCMP);
  wire tuned    = cfg.slaveTuned;
  wire cycleHit = masterCountEnable &&
                  (masterCnt_reg == cmpActive_reg.masterCycle);
  wire masterOvf = masterCountEnable && !pwmMode &&
                   (masterCnt_reg == ttp_pkg::CNT_MAX);
  wire slaveRun = tuned ? masterCountEnable : slaveCountEnable;
  wire slaveClr = (tuned && pwmMode) ? cycleHit : 1'b0;
  wire zeroWrite = optionWrite && !optionWrData[ttp_pkg::OPT_OVF_BIT];

  // Overflow flag: bit-clear loses to set, plain write wins over set
  wire ovfFlag_next = zeroWrite ? 1'b0 :
                      masterOvf ? 1'b1 :
                      overflowBitClear ? 1'b0 :
                      countOverflowFlag;

  genvar gi;
  generate
    for (gi = 0; gi < 6; gi++) begin : gStage
      always_ff @(posedge clk) begin
        if (reset)
          cmpStage_reg[gi*16 +: 16] <= ttp_pkg::CNT_ZERO;
        else if (clkEn && cmpWrStrobe[gi])
          cmpStage_reg[gi*16 +: 16] <= cmpWrData[gi*16 +: 16];
      end
    end
  endgenerate

  // Strobe bit 4 is master duty one (struct order, high first)
  wire armWrite = cmpWrStrobe[4];
  wire loadNow  = !masterCountEnable || (batchArmed_reg && cycleHit);

  always_ff @(posedge clk) begin
    if (reset) begin
      cmpActive_reg  <= '0;
      batchArmed_reg <= 1'b0;
      masterCnt_reg  <= ttp_pkg::CNT_ZERO;
      slaveCnt_reg   <= ttp_pkg::CNT_ZERO;
      shot_reg       <= ttp_pkg::ST_IDLE;
      shotCnt_reg    <= ttp_pkg::CNT_ZERO;
      countOverflowFlag <= 1'b0;
      counterReadBuffer <= ttp_pkg::CNT_ZERO;
      oneshotOut     <= 1'b0;
      eventDetect    <= 1'b0;
      masterPwmOut   <= 4'h0;
      slavePwmOut    <= 2'h0;
      cycleMatchIrq  <= 1'b0;
    end else if (clkEn) begin
      if (loadNow)
        cmpActive_reg <= cmpStage_reg;
      if (armWrite)
        batchArmed_reg <= 1'b1;
      else if (batchArmed_reg && cycleHit)
        batchArmed_reg <= 1'b0;
      if (!masterCountEnable)
        masterCnt_reg <= ttp_pkg::CNT_ZERO;
      else if (pwmMode && cycleHit)
        masterCnt_reg <= ttp_pkg::CNT_ZERO;
      else
        masterCnt_reg <= 16'(masterCnt_reg + ttp_pkg::CNT_ONE);
      if (!slaveRun || slaveClr)
        slaveCnt_reg <= ttp_pkg::CNT_ZERO;
      else
        slaveCnt_reg <= 16'(slaveCnt_reg + ttp_pkg::CNT_ONE);
      shot_reg          <= shot_next;
      shotCnt_reg       <= shotCnt_next;
      countOverflowFlag <= ovfFlag_next;
      counterReadBuffer <= masterCnt_reg;
      oneshotOut        <= (shot_next == ttp_pkg::ST_PULSE);
      eventDetect       <= evtFire;
      cycleMatchIrq     <= cycleHit;
      masterPwmOut <= (pwmMode && allCmp && masterCountEnable) ? {
        masterCnt_reg < cmpActive_reg.masterDuty3,
        masterCnt_reg < cmpActive_reg.masterDuty2,
        masterCnt_reg < cmpActive_reg.masterDuty1,
        1'b0} : 4'h0;
      slavePwmOut <= (tuned && slaveRun &&
        cfg.slaveCcs == ttp_pkg::SCCS_ALLCMP) ? {
        slaveCnt_reg < cmpActive_reg.slaveDuty1,
        slaveCnt_reg < cmpActive_reg.slaveDuty0} : 2'h0;
    end
  end

  a_ovf_bitclr_set: assert property (@(posedge clk) disable iff (reset)
    clkEn && masterOvf && overflowBitClear && !zeroWrite
    |=> countOverflowFlag)
    else $error("bit-clear lost an overflow");
  a_ovf_zero_write: assert property (@(posedge clk) disable iff (reset)
    clkEn && zeroWrite |=> !countOverflowFlag)
    else $error("option write did not clear flag");
  a_shot_illegal: assert property (@(posedge clk) disable iff (reset)
    clkEn && shot_reg == ttp_pkg::ST_IDLE && !shotLegal
    |=> shot_reg == ttp_pkg::ST_IDLE)
    else $error("one-shot started with bad compares");
  a_slave_follow: assert property (@(posedge clk) disable iff (reset)
    clkEn && tuned && masterCountEnable && $past(tuned) && $past(clkEn)
    |-> slaveCnt_reg == masterCnt_reg || !$past(masterCountEnable))
    else $error("slave counter left the master");
  a_batch_load: assert property (@(posedge clk) disable iff (reset)
    clkEn && batchArmed_reg && cycleHit && !armWrite
    |=> cmpActive_reg == $past(cmpStage_reg) && !batchArmed_reg)
    else $error("batch update missed");
  a_no_early_load: assert property (@(posedge clk) disable iff (reset)
    clkEn && masterCountEnable && !cycleHit |=> $stable(cmpActive_reg))
    else $error("compares changed mid-cycle");
  a_pwm_cycle: assert property (@(posedge clk) disable iff (reset)
    clkEn && pwmMode && cycleHit |=> masterCnt_reg == ttp_pkg::CNT_ZERO)
    else $error("cycle match did not clear counter");
  a_stop_clear: assert property (@(posedge clk) disable iff (reset)
    clkEn && !masterCountEnable |=> masterCnt_reg == ttp_pkg::CNT_ZERO)
    else $error("stop did not clear counter");
  a_arm_write: assert property (@(posedge clk) disable iff (reset)
    clkEn && armWrite |=> batchArmed_reg)
    else $error("duty one write did not arm");
endmodule

// ===== tb/ttp_timer_tb.sv
// Testbench for the tuned timer: event edges, one-shot, PWM, overflow.
// Assumes the timer package and design are compiled before this file.
`timescale 1ns/1ps
module ttp_timer_tb;
  logic              clk = 1'b0;
  logic              ce = 1'b1;
  logic              reset = 1'b1;
  ttp_pkg::ttp_cfg_s cfg = '0;
  logic              mEn = 1'b0;
  ttp_pkg::ttp_cmp_s cmpD = '0;
  logic [5:0]        cmpS = 6'h00;
  logic [15:0]       osFirst = 16'h0000;
  logic [15:0]       osSecond = 16'h0000;
  logic [1:0]        trigSel = 2'h1;
  logic [1:0]        evSel = 2'h0;
  logic              trigPin = 1'b0;
  logic              eventPin = 1'b0;
  logic              ovClr = 1'b0;
  logic              optWr = 1'b0;
  logic [7:0]        optD = 8'h00;
  logic              osOut;
  logic              evDet;
  logic              ovFlag;
  logic              irq;
  logic [15:0]       cntRd;
  logic [3:0]        mPwm;
  logic [1:0]        sPwm;
  int                n_mismatch = 0;
  int                total_checks = 0;
  int                hi [7];
  int                f1;
  int                f2;

  ttp_timer u_dut (
    .clk(clk), .reset(reset), .clkEn(ce), .cfg(cfg),
    .masterCountEnable(mEn), .slaveCountEnable(1'b0),
    .cmpWrData(cmpD), .cmpWrStrobe(cmpS),
    .oneshotCompareFirst(osFirst), .oneshotCompareSecond(osSecond),
    .triggerEdgeSel(trigSel), .eventEdgeSel(evSel),
    .trigPin(trigPin), .eventPin(eventPin),
    .overflowBitClear(ovClr), .optionWrite(optWr), .optionWrData(optD),
    .oneshotOut(osOut), .eventDetect(evDet), .countOverflowFlag(ovFlag),
    .counterReadBuffer(cntRd), .masterPwmOut(mPwm),
    .slavePwmOut(sPwm), .cycleMatchIrq(irq)
  );

  initial begin
    forever #5 clk = ~clk;
  end

  task automatic test_done();
    $display("Checks %0d, mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic chk(logic [15:0] got, logic [15:0] exp, string msg);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: %s got %0h exp %0h", $time, msg,
               got, exp);
    end
  endtask

  task automatic waitHi(ref logic sig, input int lim);
    int i;
    i = 0;
    do begin
      @(negedge clk);
      i++;
    end while (sig !== 1'b1 && i < lim);
    if (sig !== 1'b1) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: wait timed out", $time);
      test_done();
    end
  endtask

  task automatic edges(logic [1:0] sel, int exp);
    int n;
    n = 0;
    @(posedge clk) evSel <= sel;
    @(posedge clk) eventPin <= 1'b1;
    repeat (8) begin
      @(negedge clk);
      n += evDet;
    end
    @(posedge clk) eventPin <= 1'b0;
    repeat (8) begin
      @(negedge clk);
      n += evDet;
    end
    chk(16'(n), 16'(exp), "event pulses");
  endtask

  task automatic shot(logic [15:0] f, logic [15:0] s, int exp,
                      output int first);
    int w;
    w = 0;
    first = 0;
    @(posedge clk);
    trigPin <= 1'b0;
    osFirst <= f;
    osSecond <= s;
    repeat (4) @(posedge clk);
    trigPin <= 1'b1;
    for (int k = 1; k <= 30; k++) begin
      @(negedge clk);
      if (osOut === 1'b1 && first == 0) first = k;
      w += osOut;
    end
    chk(16'(w), 16'(exp), "one-shot width");
  endtask

  task automatic wrCmp(ttp_pkg::ttp_cmp_s d, logic [5:0] s);
    @(posedge clk);
    cmpD <= d;
    cmpS <= s;
    @(posedge clk);
    cmpS <= 6'h00;
  endtask

  // Counts high cycles of each output over one 10-cycle period
  task automatic period();
    waitHi(irq, 40);
    hi = '{default: 0};
    repeat (10) begin
      @(negedge clk);
      for (int b = 0; b < 4; b++) hi[b] += mPwm[b];
      hi[4] += sPwm[0];
      hi[5] += sPwm[1];
      hi[6] += irq;
    end
  endtask

  initial begin
    int expHi [7];
    int w;
    repeat (10) @(posedge clk);
    reset <= 1'b0;
    @(negedge clk);
    chk(16'({osOut, evDet, ovFlag, irq, mPwm, sPwm}), 16'h0000, "reset");
    chk(cntRd, 16'h0000, "reset count");
    edges(ttp_pkg::EDGE_NONE, 0);
    edges(ttp_pkg::EDGE_RISE, 1);
    edges(ttp_pkg::EDGE_FALL, 1);
    edges(ttp_pkg::EDGE_BOTH, 2);
    @(posedge clk);
    cfg.masterMode <= ttp_pkg::MODE_ONESHOT;
    mEn <= 1'b1;
    shot(16'h0004, 16'h0002, 3, f1);
    shot(16'h0006, 16'h0004, 3, f2);
    chk(16'(f2 - f1), 16'h0002, "one-shot delay");
    shot(16'h0005, 16'h0005, 1, f1);
    shot(16'h0004, 16'h0005, 0, f1);
    @(posedge clk);
    mEn <= 1'b0;
    cfg <= '{ttp_pkg::MODE_PWM, ttp_pkg::CCS_ALLCMP, ttp_pkg::MODE_FREERUN,
             ttp_pkg::SCCS_ALLCMP, 1'b1};
    wrCmp('{16'h0009, 16'h0003, 16'h0005, 16'h0000, 16'h0002, 16'h0007},
          6'h3F);
    @(posedge clk) mEn <= 1'b1;
    period();
    expHi = '{0, 3, 5, 0, 2, 7, 1};
    for (int b = 0; b < 7; b++) chk(16'(hi[b]), 16'(expHi[b]), "pwm");
    chk(16'(hi[6]), 16'h0001, "cycle match");
    chk(16'(hi[4] + hi[5]), 16'h0009, "slave tuned");
    wrCmp('{16'h0009, 16'h0003, 16'h0008, 16'h0000, 16'h0002, 16'h0007},
          6'h08);
    period();
    period();
    chk(16'(hi[2]), 16'h0005, "unarmed duty");
    wrCmp(cmpD, 6'h10);
    period();
    period();
    chk(16'(hi[2]), 16'h0008, "batch duty");
    chk(16'(hi[1]), 16'h0003, "batch same");
    @(posedge clk) mEn <= 1'b0;
    w = 0;
    repeat (30) begin
      @(negedge clk);
      w += irq;
    end
    chk(16'(w), 16'h0000, "stopped");
    chk(cntRd, 16'h0000, "stopped count");
    @(posedge clk);
    cfg.masterMode <= ttp_pkg::MODE_FREERUN;
    mEn <= 1'b1;
    // Clock enable low must freeze the running count
    @(posedge clk) ce <= 1'b0;
    repeat (3) @(negedge clk);
    w = int'(cntRd);
    repeat (3) @(negedge clk);
    chk(cntRd, 16'(w), "frozen count");
    @(posedge clk) ce <= 1'b1;
    // Bounded wait until the count read back is three below the wrap
    w = 0;
    while (cntRd !== 16'hFFFD && w < 70000) begin
      @(negedge clk);
      w++;
    end
    chk(cntRd, 16'hFFFD, "count before wrap");
    if (cntRd !== 16'hFFFD) test_done();
    // Bit-clear lands on the very cycle the counter sits at its maximum
    @(posedge clk) ovClr <= 1'b1;
    @(posedge clk) ovClr <= 1'b0;
    @(negedge clk);
    chk(16'(ovFlag), 16'h0001, "clear met overflow");
    @(posedge clk);
    optWr <= 1'b1;
    optD <= 8'h01;
    @(posedge clk) optWr <= 1'b0;
    @(negedge clk);
    chk(16'(ovFlag), 16'h0001, "option bit0 one");
    @(posedge clk) ovClr <= 1'b1;
    @(posedge clk) ovClr <= 1'b0;
    repeat (2) @(negedge clk);
    chk(16'(ovFlag), 16'h0000, "bit clear");
    @(posedge clk);
    optWr <= 1'b1;
    optD <= 8'h00;
    @(posedge clk) optWr <= 1'b0;
    @(negedge clk);
    chk(16'(ovFlag), 16'h0000, "option bit0 zero");
    test_done();
  end
endmodule
